//--- hw/drs_pkg.sv
// constants and types shared by the display reset sequencer
`default_nettype none
package drs_pkg;
  // system clock rate
  localparam int unsigned CLK_HZ          = 32'h017D_7840;  // 25 MHz
  localparam int unsigned HZ_PER_KHZ      = 1000;
  localparam int unsigned HZ_PER_MHZ      = 1000000;
  // reset pin pulse classification, in microseconds
  localparam int unsigned SPIKE_REJECT_US = 5;    // shorter low pulses are dropped
  localparam int unsigned FULL_RESET_US   = 9;    // longer low pulses always reset
  // in whole cycles: reject time rounded up, full reset time rounded down
  localparam int unsigned SPIKE_REJECT_CYC =
    (SPIKE_REJECT_US * CLK_HZ + HZ_PER_MHZ - 1) / HZ_PER_MHZ;
  localparam int unsigned FULL_RESET_CYC   = (FULL_RESET_US * CLK_HZ) / HZ_PER_MHZ;
  // reset cancel limits, in milliseconds (longest time, rounded down)
  localparam int unsigned CANCEL_SLEEP_IN_MS   = 5;
  localparam int unsigned CANCEL_SLEEP_OUT_MS  = 120;
  localparam int unsigned CANCEL_SLEEP_IN_CYC  = CANCEL_SLEEP_IN_MS * (CLK_HZ / HZ_PER_KHZ);
  localparam int unsigned CANCEL_SLEEP_OUT_CYC = CANCEL_SLEEP_OUT_MS * (CLK_HZ / HZ_PER_KHZ);
  // counter widths
  localparam int unsigned SPIKE_CNT_W  = 8;
  localparam int unsigned CANCEL_CNT_W = 22;
  // non-volatile settings image: three id bytes then the common voltage word
  localparam int unsigned NVM_ADDR_W   = 2;
  localparam int unsigned NVM_DATA_W   = 8;
  localparam int unsigned ID_BYTES     = 3;
  localparam logic [1:0]  NVM_ADDR_FIRST = 2'h0;
  localparam logic [1:0]  NVM_ADDR_CV    = 2'h3;   // last word of the image
  // hardware reset defaults of the loaded registers
  localparam logic [7:0]  ID_DEFAULT   = 8'h00;
  localparam logic [7:0]  CV_DEFAULT   = 8'h00;
  // sequencer states
  typedef enum logic [2:0] {
    DRS_ST_RESET,    // filtered reset held
    DRS_ST_LOAD,     // reading the settings image
    DRS_ST_SETTLE,   // waiting out the cancel time
    DRS_ST_READY     // commands accepted
  } drs_state_e;
endpackage
`default_nettype wire

//--- hw/drs_spike_filter.sv
// spike filter on the active-low hardware reset pin
`default_nettype none
module drs_spike_filter (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic hw_reset_n,
  output var  logic rst_req_q
);
  logic [drs_pkg::SPIKE_CNT_W-1:0] cnt_q;  // cycles the pin has disagreed with rst_req_q
  logic                            raw;    // pin level as an active-high request

  assign raw = ~hw_reset_n;

  // the request flips only after the pin holds the other level for the reject time;
  // this drops short lows and also short highs inside a valid low pulse
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q     <= '0;
      rst_req_q <= 1'b0;
    end else if (raw == rst_req_q) begin
      cnt_q <= '0;
    end else if (cnt_q == drs_pkg::SPIKE_CNT_W'(drs_pkg::SPIKE_REJECT_CYC - 1)) begin
      cnt_q     <= '0;
      rst_req_q <= raw;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [drs_pkg::SPIKE_CNT_W-1:0] low_run_q;   // consecutive low cycles, saturating
  logic [drs_pkg::SPIKE_CNT_W-1:0] high_run_q;  // consecutive high cycles, saturating

  // run-length helpers for the checks only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_run_q  <= '0;
      high_run_q <= '0;
    end else begin
      low_run_q  <= !raw ? '0 : (&low_run_q ? low_run_q : low_run_q + 1'b1);
      high_run_q <= raw ? '0 : (&high_run_q ? high_run_q : high_run_q + 1'b1);
    end
  end

  AST_SPIKE_REJECT: assert property (
    $rose(rst_req_q) |-> $past(low_run_q) >= drs_pkg::SPIKE_CNT_W'(drs_pkg::SPIKE_REJECT_CYC - 1))
    else $error("reset taken from a pulse shorter than the reject time");
  AST_FULL_RESET: assert property (
    low_run_q >= drs_pkg::SPIKE_CNT_W'(drs_pkg::FULL_RESET_CYC) |-> rst_req_q)
    else $error("long reset pulse not taken");
  AST_HIGH_GLITCH: assert property (
    $fell(rst_req_q) |-> $past(high_run_q) >= drs_pkg::SPIKE_CNT_W'(drs_pkg::SPIKE_REJECT_CYC - 1))
    else $error("short high glitch ended the reset");
endmodule
`default_nettype wire

//--- hw/drs_top.sv
// display reset sequencer: pin filtering, settings reload and reset cancel timing
// Notes on behaviour
// - low reset pin resets the whole device
// - ignore lows under 5us, reset over 9us
// - reject short high glitches inside reset pulse
// - reload ids and settings after each release
// - cancel done in 5ms or 120ms by mode
// - display blank during the reset period
// - registers hold defaults while reset is held, ids and settings reload after
`default_nettype none
module drs_top #(
  parameter int unsigned CANCEL_SLEEP_IN_CYC  = drs_pkg::CANCEL_SLEEP_IN_CYC,
  parameter int unsigned CANCEL_SLEEP_OUT_CYC = drs_pkg::CANCEL_SLEEP_OUT_CYC
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic                          hw_reset_n,
  input  wire logic                          cmd_valid,
  input  wire logic                          cmd_sleep_out,
  input  wire logic [drs_pkg::NVM_DATA_W-1:0] nvm_rdata,
  output var  logic                          nvm_rd_q,
  output var  logic [drs_pkg::NVM_ADDR_W-1:0] nvm_addr_q,
  output var  logic [7:0]                    id_byte0_q,
  output var  logic [7:0]                    id_byte1_q,
  output var  logic [7:0]                    id_byte2_q,
  output var  logic [7:0]                    common_voltage_setting_q,
  output var  logic                          display_blank_q,
  output var  logic                          sleep_in_q,
  output var  logic                          cmd_ready_q,
  output var  logic                          loading_q
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic                               rst_req;      // filtered reset request
  drs_pkg::drs_state_e                state_q;      // sequencer state
  logic                               cap_q;        // settings word on nvm_rdata now
  logic [drs_pkg::NVM_ADDR_W-1:0]     cap_idx_q;    // index of that word
  logic                               was_out_q;    // sleep-out held when reset came
  logic [drs_pkg::CANCEL_CNT_W-1:0]   cancel_cnt_q; // cycles since release
  logic [drs_pkg::CANCEL_CNT_W-1:0]   cancel_lim;   // last cycle of cancel time
  logic [7:0]                         id_q [drs_pkg::ID_BYTES]; // id byte store

  // true when the captured word belongs to the given image slot
  function automatic logic word_hit(input logic                        cap,
                                    input logic [drs_pkg::NVM_ADDR_W-1:0] idx,
                                    input logic [drs_pkg::NVM_ADDR_W-1:0] slot);
    word_hit = cap && (idx == slot);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin filter
  drs_spike_filter i_drs_spike_filter (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .hw_reset_n (hw_reset_n),
    .rst_req_q  (rst_req)
  );

  // cancel limit depends on the sleep mode in force when reset came
  assign cancel_lim = was_out_q ?
    drs_pkg::CANCEL_CNT_W'(CANCEL_SLEEP_OUT_CYC - 1) :
    drs_pkg::CANCEL_CNT_W'(CANCEL_SLEEP_IN_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state; power-on reset starts a load just like a pin release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= drs_pkg::DRS_ST_LOAD;
    end else if (rst_req) begin
      state_q <= drs_pkg::DRS_ST_RESET;
    end else begin
      case (state_q)
        drs_pkg::DRS_ST_RESET: begin
          state_q <= drs_pkg::DRS_ST_LOAD;
        end
        drs_pkg::DRS_ST_LOAD: begin
          // leave once the last word has been captured
          if (word_hit(cap_q, cap_idx_q, drs_pkg::NVM_ADDR_CV)) begin
            state_q <= drs_pkg::DRS_ST_SETTLE;
          end
        end
        drs_pkg::DRS_ST_SETTLE: begin
          if (cancel_cnt_q >= cancel_lim) begin
            state_q <= drs_pkg::DRS_ST_READY;
          end
        end
        drs_pkg::DRS_ST_READY: begin
          state_q <= drs_pkg::DRS_ST_READY;
        end
        default: begin
          state_q <= drs_pkg::DRS_ST_RESET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cancel timer counts from release; mode is caught when reset starts
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cancel_cnt_q <= '0;
      was_out_q    <= 1'b0;
    end else if (rst_req) begin
      cancel_cnt_q <= '0;
      // catch mode on the first reset cycle only
      if (state_q != drs_pkg::DRS_ST_RESET) begin
        was_out_q <= ~sleep_in_q;
      end
    end else if (state_q != drs_pkg::DRS_ST_READY) begin
      cancel_cnt_q <= cancel_cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settings image reads: one read per cycle, data one cycle later
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      nvm_rd_q   <= 1'b1;
      nvm_addr_q <= drs_pkg::NVM_ADDR_FIRST;
      cap_q      <= 1'b0;
      cap_idx_q  <= drs_pkg::NVM_ADDR_FIRST;
    end else begin
      cap_q     <= nvm_rd_q;
      cap_idx_q <= nvm_addr_q;
      if (rst_req) begin
        nvm_rd_q   <= 1'b0;
        nvm_addr_q <= drs_pkg::NVM_ADDR_FIRST;
        cap_q      <= 1'b0;
      end else if (state_q == drs_pkg::DRS_ST_RESET) begin
        nvm_rd_q   <= 1'b1;
        nvm_addr_q <= drs_pkg::NVM_ADDR_FIRST;
      end else if (nvm_rd_q) begin
        // stop after the last word, otherwise step on
        if (nvm_addr_q == drs_pkg::NVM_ADDR_CV) begin
          nvm_rd_q <= 1'b0;
        end else begin
          nvm_addr_q <= nvm_addr_q + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loaded registers: defaults while reset is held, image words on capture
  for (genvar g = 0; g < drs_pkg::ID_BYTES; g++) begin : g_id
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        id_q[g] <= drs_pkg::ID_DEFAULT;
      end else if (rst_req) begin
        id_q[g] <= drs_pkg::ID_DEFAULT;
      end else if (word_hit(cap_q, cap_idx_q, drs_pkg::NVM_ADDR_W'(g))) begin
        id_q[g] <= nvm_rdata;
      end
    end
  end

  assign id_byte0_q = id_q[0];
  assign id_byte1_q = id_q[1];
  assign id_byte2_q = id_q[2];

  // common voltage setting
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      common_voltage_setting_q <= drs_pkg::CV_DEFAULT;
    end else if (rst_req) begin
      common_voltage_setting_q <= drs_pkg::CV_DEFAULT;
    end else if (word_hit(cap_q, cap_idx_q, drs_pkg::NVM_ADDR_CV)) begin
      common_voltage_setting_q <= nvm_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep mode, blanking and command acceptance
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sleep_in_q      <= 1'b1;
      display_blank_q <= 1'b1;
    end else if (rst_req || state_q != drs_pkg::DRS_ST_READY) begin
      // commands arriving before the cancel time ends have no effect
      sleep_in_q      <= 1'b1;
      display_blank_q <= 1'b1;
    end else if (cmd_valid && cmd_ready_q) begin
      sleep_in_q      <= ~cmd_sleep_out;
      display_blank_q <= ~cmd_sleep_out;
    end
  end

  // ready and busy flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_ready_q <= 1'b0;
      loading_q   <= 1'b1;
    end else begin
      cmd_ready_q <= !rst_req && state_q == drs_pkg::DRS_ST_READY;
      loading_q   <= !rst_req && state_q == drs_pkg::DRS_ST_LOAD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_ENTER_RESET: assert property (
    rst_req |=> !cmd_ready_q && display_blank_q && sleep_in_q)
    else $error("reset request did not stop the device");
  AST_LOAD_START: assert property (
    $fell(rst_req) |-> ##1 nvm_rd_q && nvm_addr_q == drs_pkg::NVM_ADDR_FIRST)
    else $error("settings reload did not start after release");
  AST_LOAD_DONE: assert property (
    $rose(loading_q) |-> ##[1:8] $fell(loading_q))
    else $error("settings reload did not finish");
  AST_CANCEL_TIME: assert property (
    $rose(cmd_ready_q) |-> $past(cancel_cnt_q, 2) == cancel_lim)
    else $error("reset cancel ended at the wrong time");
  AST_BLANK: assert property (
    !cmd_ready_q |-> display_blank_q)
    else $error("display not blank during reset period");
  AST_DEFAULTS: assert property (
    rst_req ##1 rst_req |-> common_voltage_setting_q == drs_pkg::CV_DEFAULT &&
                            id_byte0_q == drs_pkg::ID_DEFAULT)
    else $error("registers not at defaults during reset");
  AST_CMD_IGNORED: assert property (
    cmd_valid && !cmd_ready_q |=> sleep_in_q)
    else $error("command acted on before the device was ready");
  AST_SLEEP_IN_AFTER: assert property (
    $rose(cmd_ready_q) |-> sleep_in_q && display_blank_q)
    else $error("device left reset outside sleep-in");
  AST_SLEEP_OUT: assert property (
    cmd_valid && cmd_ready_q && cmd_sleep_out && !rst_req |=> !sleep_in_q && !display_blank_q)
    else $error("sleep-out command not obeyed");

  COV_RESET_SEEN: cover property ($fell(rst_req));
  COV_READY_FROM_OUT: cover property ($rose(cmd_ready_q) && was_out_q);
  COV_SLEEP_OUT: cover property (cmd_valid && cmd_ready_q && cmd_sleep_out);
  COV_EARLY_CMD: cover property (cmd_valid && loading_q);
endmodule
`default_nettype wire

//--- verif/drs_host_model.sv
// host and settings memory model facing the display reset sequencer
`default_nettype none
module drs_host_model (
  input  wire logic                           sys_clk,
  input  wire logic                           nvm_rd_q,
  input  wire logic [drs_pkg::NVM_ADDR_W-1:0] nvm_addr_q,
  input  wire logic                           cmd_ready_q,
  input  wire logic [7:0]                     image_base,
  output var  logic                           hw_reset_n,
  output var  logic                           cmd_valid,
  output var  logic                           cmd_sleep_out,
  output var  logic [drs_pkg::NVM_DATA_W-1:0] nvm_rdata,
  output var  int                             read_count
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_fails;  // commands whose wait for readiness ran out
  //////////////////////////////////////////////////////////////////////////////
  // idle values: pin released, no command
  initial begin
    wait_fails    = 0;
    hw_reset_n    = 1'b1;  // pin idles high until a reset is wanted
    cmd_valid     = 1'b0;
    cmd_sleep_out = 1'b0;
    nvm_rdata     = 8'h00;
    read_count    = 0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // settings memory: word is base plus index, one cycle read latency
  always @(posedge sys_clk) begin
    if (nvm_rd_q) begin
      nvm_rdata  <= image_base + 8'(nvm_addr_q);
      read_count <= read_count + 1;
    end else begin
      nvm_rdata <= ~nvm_rdata;  // stale word: changes every cycle
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // hold the pin low for lo_cyc edges, then release it
  task automatic pin_low(input int lo_cyc);
    hw_reset_n <= 1'b0;  // host asserts the pin to start a reset
    repeat (lo_cyc) @(posedge sys_clk);
    hw_reset_n <= 1'b1;
  endtask
  // one-cycle sleep command; unless early, wait until the device is ready
  task automatic send_cmd(input logic sleep_out, input bit early);
    int n;
    n = 0;
    while (!early && cmd_ready_q !== 1'b1 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 1000) begin
      wait_fails++;  // the bench counts this as a mismatch
    end
    cmd_valid     <= 1'b1;
    cmd_sleep_out <= sleep_out;
    @(posedge sys_clk);
    cmd_valid     <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verif/tb_display_reset_sequencer.sv
// self-checking testbench of the display reset sequencer
`default_nettype none
module tb_display_reset_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IN_CYC  = 40;   // shortened cancel time, sleep-in
  localparam int OUT_CYC = 80;   // shortened cancel time, sleep-out
  localparam int FILT    = 125;  // filter length, 5 us at 25 MHz
  logic       sys_clk, rst, hw_reset_n, cmd_valid, cmd_sleep_out, nvm_rd_q;
  logic       display_blank_q, sleep_in_q, cmd_ready_q, loading_q;
  logic [1:0] nvm_addr_q;
  logic [7:0] nvm_rdata, id_byte0_q, id_byte1_q, id_byte2_q, common_voltage_setting_q;
  logic [7:0] image_base;
  int         read_count, miscompares, check_count, n, c0;
  //////////////////////////////////////////////////////////////////////////////
  // design and far-side model
  drs_top #(.CANCEL_SLEEP_IN_CYC(IN_CYC), .CANCEL_SLEEP_OUT_CYC(OUT_CYC)) i_drs_top (
    .sys_clk, .rst, .hw_reset_n, .cmd_valid, .cmd_sleep_out, .nvm_rdata, .nvm_rd_q,
    .nvm_addr_q, .id_byte0_q, .id_byte1_q, .id_byte2_q, .common_voltage_setting_q,
    .display_blank_q, .sleep_in_q, .cmd_ready_q, .loading_q);
  drs_host_model i_drs_host_model (
    .sys_clk, .nvm_rd_q, .nvm_addr_q, .cmd_ready_q, .image_base, .hw_reset_n,
    .cmd_valid, .cmd_sleep_out, .nvm_rdata, .read_count);
  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  // compare tasks and helpers
  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_win(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  // loaded image must equal base plus word index
  task automatic check_image(input logic [7:0] b);
    check_byte(id_byte0_q, b);
    check_byte(id_byte1_q, b + 8'h01);
    check_byte(id_byte2_q, b + 8'h02);
    check_byte(common_voltage_setting_q, b + 8'h03);
  endtask
  // bounded wait for commands to be accepted; looks at falling edges, where the
  // flag has settled, and counts them in n
  task automatic wait_ready();
    n = 0;
    @(negedge sys_clk);
    while (cmd_ready_q !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 1000) begin
        miscompares++;
        report_and_stop();
      end
    end
  endtask
  task automatic report_and_stop();
    miscompares = miscompares + i_drs_host_model.wait_fails;  // expired host waits
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_power_up();
    i_drs_host_model.send_cmd(1'b1, 1'b1);  // refused while loading
    wait_ready();
    check_win(n, IN_CYC - 10, IN_CYC + 15);
    check_bit(sleep_in_q, 1'b1);
    check_bit(display_blank_q, 1'b1);
    check_image(8'h31);
    check_bit(loading_q, 1'b0);
    $display("test power_up done");
  endtask
  task automatic t_sleep_cmds();
    @(posedge sys_clk);
    i_drs_host_model.send_cmd(1'b1, 1'b0);
    @(negedge sys_clk);
    check_bit(display_blank_q, 1'b0);
    @(posedge sys_clk);
    i_drs_host_model.send_cmd(1'b0, 1'b0);
    @(negedge sys_clk);
    check_bit(sleep_in_q, 1'b1);
    @(posedge sys_clk);
    i_drs_host_model.send_cmd(1'b1, 1'b0);
    @(negedge sys_clk);
    check_bit(sleep_in_q, 1'b0);
    $display("test sleep_cmds done");
  endtask
  task automatic t_short_pulse();
    c0 = read_count;
    @(posedge sys_clk);
    i_drs_host_model.pin_low(FILT - 1);
    repeat (FILT) @(posedge sys_clk);
    @(negedge sys_clk);
    check_bit(cmd_ready_q, 1'b1);
    check_bit(sleep_in_q, 1'b0);
    check_win(read_count - c0, 0, 0);
    $display("test short_pulse done");
  endtask
  task automatic t_glitch_reset();
    c0 = read_count;
    @(posedge sys_clk);
    image_base <= 8'hA4;
    i_drs_host_model.pin_low(150);
    repeat (60) @(posedge sys_clk);
    @(negedge sys_clk);
    check_bit(cmd_ready_q, 1'b0);
    check_bit(display_blank_q, 1'b1);
    @(posedge sys_clk);
    i_drs_host_model.pin_low(150);
    wait_ready();
    check_win(n, FILT + OUT_CYC - 10, FILT + OUT_CYC + 15);
    check_win(read_count - c0, 4, 4);
    check_image(8'hA4);
    check_bit(sleep_in_q, 1'b1);
    $display("test glitch_reset done");
  endtask
  task automatic t_sleep_in_reset();
    @(posedge sys_clk);
    image_base <= 8'h5C;
    i_drs_host_model.pin_low(FILT);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check_bit(cmd_ready_q, 1'b0);
    wait_ready();
    check_win(n, FILT + IN_CYC - 12, FILT + IN_CYC + 15);
    check_image(8'h5C);
    check_bit(display_blank_q, 1'b1);
    $display("test sleep_in_reset done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    miscompares = 0;
    check_count = 0;
    rst         = 1'b1;
    image_base  = 8'h31;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check_byte(id_byte0_q, 8'h00);
    check_bit(cmd_ready_q, 1'b0);
    check_bit(loading_q, 1'b1);
    check_bit(nvm_rd_q, 1'b1);
    check_byte({6'h00, nvm_addr_q}, 8'h00);
    @(posedge sys_clk);
    rst <= 1'b0;
    t_power_up();
    t_sleep_cmds();
    t_short_pulse();
    t_glitch_reset();
    t_sleep_in_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
